//--- rtcdc_pkg.sv
// Constants for the divider-chain real time clock.
// Assumes one 100 MHz clock; the count clock source arrives as sampled levels.
// Functional notes
// RULE1: The count clock is taken from one of several internal sources or an external pin, chosen by a select input.
// RULE2: Fixed divide-by-32 and divide-by-8 prescalers can each be switched in or bypassed.
// RULE3: A reloadable 16-bit timer after the prescalers drives the count input of the main count block.
// RULE4: The main count is 32 bits, built from stages of 10, 6, 6 and 10 bits from the least significant end.
// RULE5: The 32-bit count is readable as an upper half and a lower half.
// RULE6: Every stage, the 16-bit timer included, counts up only.
// RULE7: Each stage raises its own interrupt request.
// RULE8: All stage requests merge into one shared request line.
// RULE9: Only the power reset clears the state; other resets leave everything untouched.
// RULE10: On overflow a stage reloads its reload value, pulses the next stage and sets its request.
// RULE11: Each request is masked individually and the merged line is high while any enabled request is pending.
package rtcdc_pkg;
  localparam int unsigned NUM_SRC      = 4;
  localparam int unsigned SEL_W        = 2;
  localparam int unsigned PRE32_DIV    = 32;
  localparam int unsigned PRE8_DIV     = 8;
  localparam int unsigned PRE_W        = 5;
  localparam int unsigned TMR_W        = 16;
  localparam int unsigned CNT_W        = 32;
  localparam int unsigned NUM_STG      = 5;
  localparam logic [15:0] TMR_RST      = 16'h0000;
  localparam logic [31:0] CNT_RST      = 32'h0000_0000;
  localparam logic [4:0]  REQ_RST      = 5'h00;
  // Stage bit positions in the 32-bit count
  localparam int unsigned S0_LSB = 0;
  localparam int unsigned S0_W   = 10;
  localparam int unsigned S1_LSB = 10;
  localparam int unsigned S1_W   = 6;
  localparam int unsigned S2_LSB = 16;
  localparam int unsigned S2_W   = 6;
  localparam int unsigned S3_LSB = 22;
  localparam int unsigned S3_W   = 10;
endpackage : rtcdc_pkg

//--- rtcdc_stage.sv
// One reloadable up-counting stage of the chain.
// Assumes synchronous count pulses and a released, synchronised reset.
`timescale 1ns/1ns
`default_nettype none
module rtcdc_stage #(
  parameter int unsigned W = 10
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         en_i,
  input  wire logic         inc_i,
  input  wire logic [W-1:0] reload_i,
  output logic      [W-1:0] cnt_o,
  output logic              ovf_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         ovf;
  } rtcdc_stg_type;

  rtcdc_stg_type st_ff;
  rtcdc_stg_type nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ovf = 1'b0;
    if (inc_i) begin
      if (&st_ff.cnt) begin
        nxt_st.cnt = reload_i;      // see RULE10
        nxt_st.ovf = 1'b1;
      end else begin
        nxt_st.cnt = st_ff.cnt + {{(W-1){1'b0}}, 1'b1};  // see RULE6
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else if (en_i) begin
      st_ff <= nxt_st;
    end
  end

  assign cnt_o = st_ff.cnt;
  assign ovf_o = st_ff.ovf;

  a_stage_reload: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see RULE10
    (en_i && inc_i && (&cnt_o)) |=> (ovf_o && cnt_o == $past(reload_i)))
    else $error("stage did not reload on overflow");
  a_stage_up: assert property (@(posedge clk_i) disable iff (!rst_n_i)  // see RULE6
    (en_i && inc_i && !(&cnt_o)) |=> (cnt_o == $past(cnt_o) + 1'b1) && !ovf_o)
    else $error("stage did not count up by one");
endmodule : rtcdc_stage
`default_nettype wire

//--- rtcdc_top.sv
// Divider-chain real time clock: source select, prescalers, 16-bit timer, 32-bit count.
// Assumes RSTN_I is the power reset only; source levels are synchronous to MCLK_I.
`timescale 1ns/1ns
`default_nettype none
module rtcdc_top
  import rtcdc_pkg::*;
(
  input  wire logic                             MCLK_I,
  input  wire logic                             RSTN_I,
  input  wire logic                             CE_I,
  input  wire logic [rtcdc_pkg::NUM_SRC-1:0]    SRC_I,
  input  wire logic [rtcdc_pkg::SEL_W-1:0]      SRC_SEL_I,
  input  wire logic                             PRE32_EN_I,
  input  wire logic                             PRE8_EN_I,
  input  wire logic                             RUN_I,
  input  wire logic [rtcdc_pkg::TMR_W-1:0]      TMR_RELOAD_I,
  input  wire logic [rtcdc_pkg::CNT_W-1:0]      CNT_RELOAD_I,
  input  wire logic [rtcdc_pkg::NUM_STG-1:0]    REQ_MASK_I,
  input  wire logic [rtcdc_pkg::NUM_STG-1:0]    REQ_CLR_I,
  output logic      [15:0]                      COUNT_UPPER_HALF_O,
  output logic      [15:0]                      COUNT_LOWER_HALF_O,
  output logic      [rtcdc_pkg::TMR_W-1:0]      PRESCALE_TIMER_O,
  output logic      [rtcdc_pkg::NUM_STG-1:0]    REQ_O,
  output logic                                  NODE_REQ_O
);
  import rtcdc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  // Only the power reset reaches this block, so other resets cannot disturb it
  logic [1:0] rst_sync_ff;
  logic       rst_n;
  always_ff @(posedge MCLK_I or negedge RSTN_I) begin  // see RULE9
    if (!RSTN_I) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // ----------------------------------------------------------------
  // Source select and prescalers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                src_q;
    logic [PRE_W-1:0]    div32;
    logic [2:0]          div8;
    logic [NUM_STG-1:0]  req;
    logic [15:0]         upper;
    logic [15:0]         lower;
    logic [TMR_W-1:0]    tmr_out;
    logic                node;
  } rtcdc_top_type;

  rtcdc_top_type st_ff;
  rtcdc_top_type nxt_st;

  logic             src_lvl;
  logic             src_edge;
  logic             p32_tick;
  logic             p8_in;
  logic             p8_tick;
  logic             tmr_inc;
  logic [TMR_W-1:0] tmr_cnt;
  logic [NUM_STG-1:0] ovf;
  logic [CNT_W-1:0] cnt;

  assign src_lvl  = SRC_I[SRC_SEL_I];                    // see RULE1
  assign src_edge = src_lvl & ~st_ff.src_q;
  // Bypassed prescaler passes its input tick straight through
  assign p32_tick = PRE32_EN_I ? (src_edge && st_ff.div32 == PRE_W'(PRE32_DIV - 1)) : src_edge;  // see RULE2
  assign p8_in    = p32_tick;
  assign p8_tick  = PRE8_EN_I ? (p8_in && st_ff.div8 == 3'(PRE8_DIV - 1)) : p8_in;  // see RULE2
  assign tmr_inc  = p8_tick & RUN_I;

  // ----------------------------------------------------------------
  // Timer and count stages
  // ----------------------------------------------------------------
  rtcdc_stage #(.W(TMR_W)) u_prescale_timer (            // see RULE3
    .clk_i    (MCLK_I),
    .rst_n_i  (rst_n),
    .en_i     (CE_I),
    .inc_i    (tmr_inc),
    .reload_i (TMR_RELOAD_I),
    .cnt_o    (tmr_cnt),
    .ovf_o    (ovf[0])
  );

  localparam int unsigned STG_LSB [4] = '{S0_LSB, S1_LSB, S2_LSB, S3_LSB};
  localparam int unsigned STG_W   [4] = '{S0_W, S1_W, S2_W, S3_W};

  generate
    for (genvar g = 0; g < 4; g++) begin : g_stage      // see RULE4
      rtcdc_stage #(.W(STG_W[g])) u_stage (
        .clk_i    (MCLK_I),
        .rst_n_i  (rst_n),
        .en_i     (CE_I),
        .inc_i    (ovf[g]),
        .reload_i (CNT_RELOAD_I[STG_LSB[g] +: STG_W[g]]),
        .cnt_o    (cnt[STG_LSB[g] +: STG_W[g]]),
        .ovf_o    (ovf[g+1])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Requests and outputs
  // ----------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    nxt_st.src_q = src_lvl;
    if (src_edge && PRE32_EN_I) begin
      nxt_st.div32 = st_ff.div32 + PRE_W'(1);
    end
    if (p8_in && PRE8_EN_I) begin
      nxt_st.div8 = st_ff.div8 + 3'h1;
    end
    // Set beats clear so an overflow in the clear cycle is kept
    nxt_st.req = (st_ff.req & ~REQ_CLR_I) | ovf;         // see RULE7
    nxt_st.upper = cnt[31:16];                            // see RULE5
    nxt_st.lower = cnt[15:0];                             // see RULE5
    nxt_st.tmr_out = tmr_cnt;
    nxt_st.node = |(nxt_st.req & REQ_MASK_I);            // see RULE8 RULE11
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '{src_q: 1'b0, div32: '0, div8: 3'h0, req: REQ_RST,
                 upper: CNT_RST[31:16], lower: CNT_RST[15:0], tmr_out: TMR_RST, node: 1'b0};
    end else if (CE_I) begin
      st_ff <= nxt_st;
    end
  end

  assign COUNT_UPPER_HALF_O = st_ff.upper;
  assign COUNT_LOWER_HALF_O = st_ff.lower;
  assign PRESCALE_TIMER_O   = st_ff.tmr_out;
  assign REQ_O              = st_ff.req;
  assign NODE_REQ_O         = st_ff.node;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_req_sticky: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE7
    (CE_I && ovf[1]) |=> REQ_O[1])
    else $error("stage request not set on overflow");
  a_node_merge: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE11
    CE_I |=> (NODE_REQ_O == |(REQ_O & $past(REQ_MASK_I))))
    else $error("merged request wrong");
  a_chain_pulse: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE10
    (CE_I && ovf[0]) |-> (u_prescale_timer.cnt_o == $past(TMR_RELOAD_I)))
    else $error("timer overflow without reload");
  a_half_split: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE5
    CE_I |=> ({COUNT_UPPER_HALF_O, COUNT_LOWER_HALF_O} == $past(cnt)))
    else $error("count halves wrong");
  a_bypass_pass: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE2
    (CE_I && !PRE32_EN_I && !PRE8_EN_I && RUN_I && src_edge && !(&tmr_cnt))
    |=> (tmr_cnt == $past(tmr_cnt) + TMR_W'(1)))
    else $error("bypass does not pass ticks");
  a_up_only: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE6
    (CE_I && !ovf[1] && !$past(ovf[0])) |-> (cnt[9:0] == $past(cnt[9:0])))
    else $error("stage moved without tick");
  a_reset_clear: assert property (@(posedge MCLK_I)  // see RULE9
    $rose(rst_n) |-> (REQ_O == REQ_RST && !NODE_REQ_O))
    else $error("state not cleared by power reset");
  a_timer_feed: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE3
    (CE_I && !tmr_inc) |=> (tmr_cnt == $past(tmr_cnt)))
    else $error("timer moved without input tick");

  // Clock enable low must hold every counter and request
  a_freeze_state: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE6
    !CE_I |=> (tmr_cnt == $past(tmr_cnt) && cnt == $past(cnt) && REQ_O == $past(REQ_O)))
    else $error("state moved with clock enable low");
  a_req_keep: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE7
    CE_I |=> (($past(REQ_O) & ~$past(REQ_CLR_I) & ~REQ_O) == '0))
    else $error("pending request dropped without clear");
  a_req_set: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE7
    CE_I |=> (($past(ovf) & ~REQ_O) == '0))
    else $error("overflow did not set its request");
  a_req_clear: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE11
    (CE_I && REQ_CLR_I[0] && !ovf[0]) |=> !REQ_O[0])
    else $error("timer request not cleared");
  a_tmr_mirror: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE3
    CE_I |=> (PRESCALE_TIMER_O == $past(tmr_cnt)))
    else $error("timer output does not follow timer");
  a_out_reset: assert property (@(posedge MCLK_I)  // see RULE9
    !rst_n |-> (PRESCALE_TIMER_O == TMR_RST && {COUNT_UPPER_HALF_O, COUNT_LOWER_HALF_O} == CNT_RST
                && REQ_O == REQ_RST && !NODE_REQ_O))
    else $error("outputs not cleared during power reset");
  a_src_follow: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE1
    CE_I |=> (st_ff.src_q == $past(SRC_I[SRC_SEL_I])))
    else $error("edge detector not on selected source");
  a_div32_step: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE2
    (CE_I && PRE32_EN_I && src_edge && !p32_tick) |=> (st_ff.div32 == $past(st_ff.div32) + PRE_W'(1)))
    else $error("divide by 32 missed a source edge");
  a_div32_wrap: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE2
    (CE_I && PRE32_EN_I && p32_tick) |=> (st_ff.div32 == '0))
    else $error("divide by 32 did not wrap");
  a_div32_hold: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE2
    (CE_I && !PRE32_EN_I) |=> (st_ff.div32 == $past(st_ff.div32)))
    else $error("bypassed divide by 32 moved");
  a_div8_wrap: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE2
    (CE_I && PRE8_EN_I && p8_tick) |=> (st_ff.div8 == 3'h0))
    else $error("divide by 8 did not wrap");
  a_div8_hold: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE2
    (CE_I && !PRE8_EN_I) |=> (st_ff.div8 == $past(st_ff.div8)))
    else $error("bypassed divide by 8 moved");

  // Each stage steps only on the carry of the stage below it
  generate
    for (genvar k = 0; k < 4; k++) begin : g_stage_chk
      a_stage_carry: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE4
        (CE_I && ovf[k] && !(&cnt[STG_LSB[k] +: STG_W[k]]))
        |=> (cnt[STG_LSB[k] +: STG_W[k]] == $past(cnt[STG_LSB[k] +: STG_W[k]]) + 1'b1))
        else $error("count stage missed its carry");
      a_stage_still: assert property (@(posedge MCLK_I) disable iff (!rst_n)  // see RULE6
        (CE_I && !ovf[k]) |=> (cnt[STG_LSB[k] +: STG_W[k]] == $past(cnt[STG_LSB[k] +: STG_W[k]])))
        else $error("count stage moved without carry");
    end
  endgenerate
endmodule : rtcdc_top
`default_nettype wire

//--- rtcdc_top_tb_top.sv
// Self-checking bench for the divider-chain real time clock.
// Assumes rtcdc_pkg and rtcdc_top compiled first; all stimulus fixed.
`timescale 1ns/1ns
`default_nettype none
module rtcdc_top_tb_top;
  import rtcdc_pkg::*;
  logic        MCLK_I       = 1'b0;
  logic        RSTN_I       = 1'b0;
  logic        CE_I         = 1'b1;
  logic [3:0]  SRC_I        = 4'h0;
  logic [1:0]  SRC_SEL_I    = 2'h0;
  logic        PRE32_EN_I   = 1'b0;
  logic        PRE8_EN_I    = 1'b0;
  logic        RUN_I        = 1'b1;
  logic [15:0] TMR_RELOAD_I = 16'hffff;
  logic [31:0] CNT_RELOAD_I = 32'hffff_ffff;
  logic [4:0]  REQ_MASK_I   = 5'h1f;
  logic [4:0]  REQ_CLR_I    = 5'h00;
  logic [15:0] COUNT_UPPER_HALF_O;
  logic [15:0] COUNT_LOWER_HALF_O;
  logic [15:0] PRESCALE_TIMER_O;
  logic [4:0]  REQ_O;
  logic        NODE_REQ_O;
  int          num_errors   = 0;
  int          n_compared   = 0;

  rtcdc_top rtcdc_top_i (
    .MCLK_I(MCLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I), .SRC_I(SRC_I), .SRC_SEL_I(SRC_SEL_I),
    .PRE32_EN_I(PRE32_EN_I), .PRE8_EN_I(PRE8_EN_I), .RUN_I(RUN_I), .TMR_RELOAD_I(TMR_RELOAD_I),
    .CNT_RELOAD_I(CNT_RELOAD_I), .REQ_MASK_I(REQ_MASK_I), .REQ_CLR_I(REQ_CLR_I),
    .COUNT_UPPER_HALF_O(COUNT_UPPER_HALF_O), .COUNT_LOWER_HALF_O(COUNT_LOWER_HALF_O),
    .PRESCALE_TIMER_O(PRESCALE_TIMER_O), .REQ_O(REQ_O), .NODE_REQ_O(NODE_REQ_O)
  );

  initial begin
    forever #5 MCLK_I = ~MCLK_I;
  end

  // ----------------------------------------
  // Compare, stimulus and closing tasks
  // ----------------------------------------
  task automatic chk_val(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_flag(input string nm, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic chk_all(input logic [15:0] tmr, input logic [31:0] cnt, input logic [4:0] req, input logic node);
    chk_val("timer", {16'h0000, tmr}, {16'h0000, PRESCALE_TIMER_O});
    chk_val("upper", {16'h0000, cnt[31:16]}, {16'h0000, COUNT_UPPER_HALF_O});
    chk_val("lower", {16'h0000, cnt[15:0]}, {16'h0000, COUNT_LOWER_HALF_O});
    chk_val("requests", {27'h0, req}, {27'h0, REQ_O});
    chk_flag("node", node, NODE_REQ_O);
  endtask

  // Low phase between pulses; edge detect needs it
  task automatic tick(input int idx, input int n);
    repeat (n) begin
      @(posedge MCLK_I) SRC_I[idx] <= 1'b1;
      @(posedge MCLK_I) SRC_I[idx] <= 1'b0;
    end
    repeat (8) @(posedge MCLK_I);
    #1;
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic s_gate();
    tick(0, 5);
    chk_all(16'h0005, 32'h0, 5'h00, 1'b0);
    @(posedge MCLK_I) RUN_I <= 1'b0;
    tick(0, 3);
    chk_all(16'h0005, 32'h0, 5'h00, 1'b0);
    @(posedge MCLK_I) RUN_I <= 1'b1;
    CE_I <= 1'b0;
    tick(0, 3);
    @(posedge MCLK_I) CE_I <= 1'b1;
    tick(0, 0);
    chk_all(16'h0005, 32'h0, 5'h00, 1'b0);
  endtask

  task automatic s_select();
    for (int s = 0; s < 4; s++) begin
      @(posedge MCLK_I) SRC_SEL_I <= 2'(s);
      tick((s + 1) % 4, 2);
      tick(s, 1);
      chk_all(16'(6 + s), 32'h0, 5'h00, 1'b0);
    end
    @(posedge MCLK_I) SRC_SEL_I <= 2'h0;
  endtask

  task automatic s_prescale();
    @(posedge MCLK_I) PRE8_EN_I <= 1'b1;
    tick(0, 16);
    chk_all(16'h000b, 32'h0, 5'h00, 1'b0);
    @(posedge MCLK_I) PRE8_EN_I <= 1'b0;
    PRE32_EN_I <= 1'b1;
    tick(0, 64);
    chk_all(16'h000d, 32'h0, 5'h00, 1'b0);
    @(posedge MCLK_I) PRE8_EN_I <= 1'b1;
    tick(0, 256);
    chk_all(16'h000e, 32'h0, 5'h00, 1'b0);
    @(posedge MCLK_I) PRE8_EN_I <= 1'b0;
    PRE32_EN_I <= 1'b0;
  endtask

  // Reloads all ones, so each stage overflows on every carry once it wraps
  task automatic s_chain();
    int unsigned n[8] = '{1021, 1, 62, 1, 62, 1, 1022, 1};
    logic [31:0] c[8] = '{32'h3ff, 32'h7ff, 32'hffff, 32'h1_ffff, 32'h3f_ffff, 32'h7f_ffff, 32'hffff_ffff,
                          32'hffff_ffff};
    logic [4:0]  r[8] = '{5'h01, 5'h03, 5'h03, 5'h07, 5'h07, 5'h0f, 5'h0f, 5'h1f};
    tick(0, 65521);
    chk_all(16'hffff, 32'h0, 5'h00, 1'b0);
    tick(0, 1);
    chk_all(16'hffff, 32'h1, 5'h01, 1'b1);
    @(posedge MCLK_I) REQ_CLR_I <= 5'h01;
    @(posedge MCLK_I) REQ_CLR_I <= 5'h00;
    tick(0, 0);
    chk_all(16'hffff, 32'h1, 5'h00, 1'b0);
    @(posedge MCLK_I) REQ_MASK_I <= 5'h1e;
    tick(0, 1);
    chk_all(16'hffff, 32'h2, 5'h01, 1'b0);
    @(posedge MCLK_I) REQ_MASK_I <= 5'h1f;
    tick(0, 0);
    chk_flag("node", 1'b1, NODE_REQ_O);
    for (int i = 0; i < 8; i++) begin
      tick(0, int'(n[i]));
      chk_all(16'hffff, c[i], r[i], 1'b1);
    end
    // Reload values other than all ones must land on overflow
    @(posedge MCLK_I) TMR_RELOAD_I <= 16'hfff0;
    CNT_RELOAD_I <= 32'h0000_0000;
    tick(0, 1);
    chk_all(16'hfff0, 32'h0, 5'h1f, 1'b1);
    tick(0, 16);
    chk_all(16'hfff0, 32'h1, 5'h1f, 1'b1);
  endtask

  task automatic s_power();
    @(posedge MCLK_I) RSTN_I <= 1'b0;
    tick(0, 0);
    chk_all(16'h0000, 32'h0, 5'h00, 1'b0);
    @(posedge MCLK_I) RSTN_I <= 1'b1;
    tick(0, 0);
    chk_all(16'h0000, 32'h0, 5'h00, 1'b0);
  endtask

  initial begin
    repeat (10) @(posedge MCLK_I);
    RSTN_I <= 1'b1;
    tick(0, 0);
    chk_all(16'h0000, 32'h0, 5'h00, 1'b0);
    s_gate();
    s_select();
    s_prescale();
    s_chain();
    s_power();
    wrap_up();
  end

  initial begin
    repeat (200000) @(posedge MCLK_I);
    num_errors++;
    wrap_up();
  end
endmodule // rtcdc_top_tb_top
`default_nettype wire
